// >>> src/csd_pkg.sv
// Operation
// R1: no-buzz bit keeps detectors on in sleep
// R2: speed code picks internal oscillator divide
// R3: same codes divide external clock input
// R4: speed field resets to zero, 3 MHz
// R5: software keeps processor clock fast enough
// R6: oscillator control decoded only in bank one
// R7: lock only while internal oscillator clocks usb
// R8: lock-disable bit stops packet-based tuning
// R9: fine-only bit suppresses coarse retuning step
// R10: capture divider codes give 2,4,6,8
// R11: capture source: osc, ext, 32k, stopped
// R12: interval divider codes give 1,2,3,4
// R13: interval source: osc, ext, 32k, capture
// R14: 12-bit down counter, reload after zero
// R15: reload staged so half-writes never load
// R16: interrupt request on every reload
// R17: periodic timer is 4096 capture clocks
// R18: clock output pin source selection
// R19: processor source bit: osc or external
// R20: sleep forces osc; wake waits three 32k
// R21: timer clock reset gives 1 us ticks
`default_nettype none
package csd_pkg;
   localparam logic [7:0] CSD_OFS_CPU_USB_CLOCK = 8'h30;
   localparam logic [7:0] CSD_OFS_TIMER_CLOCK = 8'h31;
   localparam logic [7:0] CSD_OFS_CLOCK_OUTPUT = 8'h32;
   localparam logic [7:0] CSD_OFS_OSC_LOCK = 8'h39;
   localparam logic [8:0] CSD_OFS_OSC_CONTROL = 9'h1E0;
   localparam logic [7:0] CSD_RST_CPU_USB_CLOCK = 8'h00;
   localparam logic [7:0] CSD_RST_TIMER_CLOCK = 8'h8F;
   localparam logic [7:0] CSD_RST_CLOCK_OUTPUT = 8'h00;
   localparam logic [7:0] CSD_RST_OSC_LOCK = 8'h00;
   localparam logic [7:0] CSD_RST_OSC_CONTROL = 8'h00;
   localparam int CSD_BIT_NO_BUZZ = 5;
   localparam int CSD_BIT_LOCK_DISABLE = 0;
   localparam int CSD_BIT_FINE_ONLY = 1;
   localparam int CSD_BIT_CPU_SOURCE = 0;
   localparam int CSD_BIT_USB_SOURCE = 5;
   localparam logic [2:0] CSD_SPEED_UNDIVIDED = 3'h3;
   localparam logic [1:0] CSD_SRC_OSC = 2'h0;
   localparam logic [1:0] CSD_SRC_EXT = 2'h1;
   localparam logic [1:0] CSD_SRC_LP = 2'h2;
   localparam logic [1:0] CSD_SRC_ALT = 2'h3;
   localparam int CSD_RELOAD_WIDTH = 12;
   localparam logic [11:0] CSD_RST_RELOAD = 12'hFFF;
   localparam logic [11:0] CSD_PERIODIC_LAST = 12'hFFF;
   localparam logic [1:0] CSD_WAKE_LP_CYCLES = 2'h3;
endpackage : csd_pkg
`default_nettype wire

// >>> src/csd_clock_unit.sv
`default_nettype none
module csd_clock_unit (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [7:0] io_addr_i,
   input wire logic extended_bank_flag_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_wr_data_i,
   output logic [7:0] io_rd_data_o,
   input wire logic reload_lo_wr_i,
   input wire logic reload_hi_wr_i,
   input wire logic [7:0] reload_data_i,
   output logic [11:0] interval_reload_value_o,
   output logic [11:0] interval_count_o,
   input wire logic osc24_tick_i,
   input wire logic external_clock_input_i,
   input wire logic lp32_clock_i,
   input wire logic sleep_i,
   output logic processor_clock_o,
   output logic processor_run_o,
   output logic capture_timer_clock_o,
   output logic interval_timer_clock_o,
   output logic periodic_1024_tick_o,
   output logic interval_irq_o,
   output logic clock_output_pin_o,
   output logic osc_lock_enable_o,
   output logic osc_coarse_tune_enable_o,
   output logic detector_always_on_o,
   output logic detector_duty_cycled_o
);
   logic [7:0] cpu_usb_reg, cpu_usb_next;
   logic [7:0] timer_clk_reg, timer_clk_next;
   logic [7:0] clk_out_reg, clk_out_next;
   logic [7:0] lock_reg, lock_next;
   logic [7:0] osc_ctl_reg, osc_ctl_next;
   logic [7:0] rd_data_reg, rd_data_next;
   logic [7:0] reload_lo_reg;
   logic [11:0] reload_reg;
   logic [11:0] count_reg, count_next;
   logic [2:0] ext_sync_reg, lp_sync_reg;
   logic [6:0] cpu_div_reg;
   logic [2:0] cap_div_reg;
   logic [1:0] itm_div_reg;
   logic [11:0] periodic_reg;
   logic cpu_tick_reg, cap_tick_reg, itm_tick_reg;
   logic periodic_tick_reg, irq_reg, pin_reg;
   logic sleep_d_reg;
   logic [1:0] wake_cnt_reg;
   logic run_reg;

   // decode: bank one holds only the oscillator control register
   wire bank0 = !extended_bank_flag_i;
   wire sel_cpu_usb = bank0 && io_addr_i == csd_pkg::CSD_OFS_CPU_USB_CLOCK;
   wire sel_timer = bank0 && io_addr_i == csd_pkg::CSD_OFS_TIMER_CLOCK;
   wire sel_clk_out = bank0 && io_addr_i == csd_pkg::CSD_OFS_CLOCK_OUTPUT;
   wire sel_lock = bank0 && io_addr_i == csd_pkg::CSD_OFS_OSC_LOCK;
   wire sel_osc_ctl = extended_bank_flag_i
      && {1'b1, io_addr_i} == csd_pkg::CSD_OFS_OSC_CONTROL; // see R6

   // writable fields only; reserved bits stay zero
   assign cpu_usb_next = (io_wr_i && sel_cpu_usb)
      ? (io_wr_data_i & 8'h61) : cpu_usb_reg;
   assign timer_clk_next = (io_wr_i && sel_timer) ? io_wr_data_i
      : timer_clk_reg;
   assign clk_out_next = (io_wr_i && sel_clk_out)
      ? (io_wr_data_i & 8'h03) : clk_out_reg;
   assign lock_next = (io_wr_i && sel_lock) ? (io_wr_data_i & 8'h03)
      : lock_reg;
   assign osc_ctl_next = (io_wr_i && sel_osc_ctl)
      ? (io_wr_data_i & 8'h3F) : osc_ctl_reg;

   assign rd_data_next = !io_rd_i ? rd_data_reg
      : sel_cpu_usb ? cpu_usb_reg
      : sel_timer ? timer_clk_reg
      : sel_clk_out ? clk_out_reg
      : sel_lock ? lock_reg
      : sel_osc_ctl ? osc_ctl_reg
      : 8'h00;

   // source ticks; pin inputs pass two flops before the edge detect
   wire ext_tick = ext_sync_reg[1] && !ext_sync_reg[2];
   wire lp_tick = lp_sync_reg[1] && !lp_sync_reg[2];

   // processor clock
   wire cpu_src_ext = cpu_usb_reg[csd_pkg::CSD_BIT_CPU_SOURCE]; // see R19
   wire cpu_src_tick = cpu_src_ext ? ext_tick : osc24_tick_i;
   wire [2:0] speed = osc_ctl_reg[2:0];
   logic [6:0] cpu_div_last;
   always_comb begin
      case (speed) // see R2 see R3
         3'h0: cpu_div_last = 7'h07;
         3'h1: cpu_div_last = 7'h03;
         3'h2: cpu_div_last = 7'h01;
         3'h3: cpu_div_last = 7'h00;
         3'h4: cpu_div_last = 7'h0F;
         3'h5: cpu_div_last = 7'h1F;
         3'h6: cpu_div_last = 7'h7F;
         // reserved code: hold the reset rate rather than stall
         default: cpu_div_last = 7'h07;
      endcase
   end
   // processor clock is stopped in sleep and until recovery completes
   wire cpu_gate = run_reg && !sleep_i; // see R20
   wire cpu_wrap = cpu_div_reg >= cpu_div_last;

   // capture clock
   wire [1:0] cap_src = timer_clk_reg[5:4];
   logic cap_src_tick;
   always_comb begin
      case (cap_src) // see R11
         csd_pkg::CSD_SRC_OSC: cap_src_tick = osc24_tick_i;
         csd_pkg::CSD_SRC_EXT: cap_src_tick = ext_tick;
         csd_pkg::CSD_SRC_LP: cap_src_tick = lp_tick;
         default: cap_src_tick = 1'b0;
      endcase
   end
   // divide by 2*(code+1): 2,4,6,8
   wire [2:0] cap_div_last = {timer_clk_reg[7:6], 1'b1}; // see R10
   wire cap_wrap = cap_div_reg >= cap_div_last;

   // interval clock
   wire [1:0] itm_src = timer_clk_reg[1:0];
   logic itm_src_tick;
   always_comb begin
      case (itm_src) // see R13
         csd_pkg::CSD_SRC_OSC: itm_src_tick = osc24_tick_i;
         csd_pkg::CSD_SRC_EXT: itm_src_tick = ext_tick;
         csd_pkg::CSD_SRC_LP: itm_src_tick = lp_tick;
         default: itm_src_tick = cap_tick_reg;
      endcase
   end
   wire [1:0] itm_div_last = timer_clk_reg[3:2]; // see R12
   wire itm_wrap = itm_div_reg >= itm_div_last;

   // interval down counter: zero, then a reload tick
   wire count_zero = count_reg == 12'h000;
   assign count_next = !itm_tick_reg ? count_reg
      : count_zero ? reload_reg // see R14
      : count_reg - 12'h001;
   wire reload_event = itm_tick_reg && count_zero; // see R16

   // clock output pin
   logic pin_src_tick;
   always_comb begin
      case (clk_out_reg[1:0]) // see R18
         csd_pkg::CSD_SRC_OSC: pin_src_tick = osc24_tick_i;
         csd_pkg::CSD_SRC_EXT: pin_src_tick = ext_tick;
         csd_pkg::CSD_SRC_LP: pin_src_tick = lp_tick;
         default: pin_src_tick = cpu_tick_reg;
      endcase
   end

   wire entering_sleep = sleep_i && !sleep_d_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cpu_usb_reg <= csd_pkg::CSD_RST_CPU_USB_CLOCK;
         timer_clk_reg <= csd_pkg::CSD_RST_TIMER_CLOCK; // see R21
         clk_out_reg <= csd_pkg::CSD_RST_CLOCK_OUTPUT;
         lock_reg <= csd_pkg::CSD_RST_OSC_LOCK;
         osc_ctl_reg <= csd_pkg::CSD_RST_OSC_CONTROL; // see R4
         rd_data_reg <= 8'h00;
      end else begin
         cpu_usb_reg <= cpu_usb_next;
         if (entering_sleep) begin
            cpu_usb_reg[csd_pkg::CSD_BIT_CPU_SOURCE] <= 1'b0; // see R20
         end
         timer_clk_reg <= timer_clk_next;
         clk_out_reg <= clk_out_next;
         lock_reg <= lock_next;
         osc_ctl_reg <= osc_ctl_next;
         rd_data_reg <= rd_data_next;
      end
   end

   // low byte is held aside; only the high write commits all 12 bits
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         reload_lo_reg <= 8'h00;
         reload_reg <= csd_pkg::CSD_RST_RELOAD;
         count_reg <= csd_pkg::CSD_RST_RELOAD;
         irq_reg <= 1'b0;
      end else begin
         if (reload_lo_wr_i) begin
            reload_lo_reg <= reload_data_i; // see R15
         end
         if (reload_hi_wr_i) begin
            reload_reg <= {reload_data_i[3:0], reload_lo_reg}; // see R15
         end
         count_reg <= count_next;
         irq_reg <= reload_event;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         ext_sync_reg <= 3'h0;
         lp_sync_reg <= 3'h0;
      end else begin
         ext_sync_reg <= {ext_sync_reg[1:0], external_clock_input_i};
         lp_sync_reg <= {lp_sync_reg[1:0], lp32_clock_i};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cpu_div_reg <= 7'h00;
         cpu_tick_reg <= 1'b0;
      end else begin
         cpu_tick_reg <= cpu_gate && cpu_src_tick && cpu_wrap;
         if (!cpu_gate) begin
            cpu_div_reg <= 7'h00;
         end else if (cpu_src_tick) begin
            cpu_div_reg <= cpu_wrap ? 7'h00 : cpu_div_reg + 7'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cap_div_reg <= 3'h0;
         cap_tick_reg <= 1'b0;
         itm_div_reg <= 2'h0;
         itm_tick_reg <= 1'b0;
      end else begin
         cap_tick_reg <= cap_src_tick && cap_wrap;
         if (cap_src_tick) begin
            cap_div_reg <= cap_wrap ? 3'h0 : cap_div_reg + 3'h1;
         end
         itm_tick_reg <= itm_src_tick && itm_wrap;
         if (itm_src_tick) begin
            itm_div_reg <= itm_wrap ? 2'h0 : itm_div_reg + 2'h1;
         end
      end
   end

   // period tracks whatever rate the capture clock really has
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         periodic_reg <= 12'h000;
         periodic_tick_reg <= 1'b0;
      end else begin
         periodic_tick_reg <= cap_tick_reg
            && periodic_reg == csd_pkg::CSD_PERIODIC_LAST; // see R17
         if (cap_tick_reg) begin
            periodic_reg <= periodic_reg + 12'h001;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= pin_src_tick;
      end
   end

   // wake recovery counts 32 kHz edges before the processor runs
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         sleep_d_reg <= 1'b0;
         wake_cnt_reg <= 2'h0;
         run_reg <= 1'b1;
      end else begin
         sleep_d_reg <= sleep_i;
         if (sleep_i) begin
            run_reg <= 1'b0;
            wake_cnt_reg <= 2'h0;
         end else if (!run_reg && lp_tick) begin
            if (wake_cnt_reg == csd_pkg::CSD_WAKE_LP_CYCLES - 2'h1) begin
               run_reg <= 1'b1; // see R20
            end
            wake_cnt_reg <= wake_cnt_reg + 2'h1;
         end
      end
   end

   wire usb_from_osc = !cpu_usb_reg[csd_pkg::CSD_BIT_USB_SOURCE];
   wire lock_on = usb_from_osc // see R7
      && !lock_reg[csd_pkg::CSD_BIT_LOCK_DISABLE]; // see R8
   wire no_buzz = osc_ctl_reg[csd_pkg::CSD_BIT_NO_BUZZ];

   assign io_rd_data_o = rd_data_reg;
   assign interval_reload_value_o = reload_reg;
   assign interval_count_o = count_reg;
   assign processor_clock_o = cpu_tick_reg;
   assign processor_run_o = run_reg;
   assign capture_timer_clock_o = cap_tick_reg;
   assign interval_timer_clock_o = itm_tick_reg;
   assign periodic_1024_tick_o = periodic_tick_reg;
   assign interval_irq_o = irq_reg;
   assign clock_output_pin_o = pin_reg;
   assign osc_lock_enable_o = lock_on;
   assign osc_coarse_tune_enable_o = lock_on
      && !lock_reg[csd_pkg::CSD_BIT_FINE_ONLY]; // see R9
   assign detector_always_on_o = sleep_i && no_buzz; // see R1
   assign detector_duty_cycled_o = sleep_i && !no_buzz; // see R1
endmodule : csd_clock_unit
`default_nettype wire

// >>> dv/csd_sources.sv
`default_nettype none
module csd_sources (
   input wire logic clk_i,
   input wire logic run_i,
   output logic osc_tick_o = 1'b0,
   output logic ext_clk_o = 1'b0,
   output logic lp_clk_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   // internal oscillator halts while asleep; the 32k source keeps running
   always @(negedge clk_i) begin
      n <= n + 1;
      osc_tick_o <= run_i && (n % 5 == 0);
      ext_clk_o <= (n % 10) < 5;
      lp_clk_o <= (n % 40) < 20;
   end
endmodule : csd_sources
`default_nettype wire

// >>> dv/csd_clock_unit_properties.sv
`default_nettype none
module csd_clock_unit_properties (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [7:0] io_addr_i,
   input wire logic extended_bank_flag_i,
   input wire logic io_rd_i,
   input wire logic [7:0] io_rd_data_o,
   input wire logic reload_lo_wr_i,
   input wire logic reload_hi_wr_i,
   input wire logic [11:0] interval_reload_value_o,
   input wire logic [11:0] interval_count_o,
   input wire logic sleep_i,
   input wire logic processor_run_o,
   input wire logic capture_timer_clock_o,
   input wire logic interval_timer_clock_o,
   input wire logic periodic_1024_tick_o,
   input wire logic interval_irq_o,
   input wire logic detector_always_on_o,
   input wire logic detector_duty_cycled_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   property p_duty;
      sleep_i |-> detector_always_on_o ^ detector_duty_cycled_o;
   endproperty
   a_duty: assert property (p_duty)
      else $error("detector mode wrong in sleep");
   property p_bank;
      io_rd_i && extended_bank_flag_i && io_addr_i != 8'hE0
         |=> io_rd_data_o == 8'h00;
   endproperty
   a_bank: assert property (p_bank)
      else $error("second bank read not empty");
   property p_dec;
      interval_timer_clock_o && interval_count_o != 12'h000
         |=> interval_count_o == $past(interval_count_o) - 12'h001;
   endproperty
   a_dec: assert property (p_dec)
      else $error("count did not step down");
   property p_load;
      interval_timer_clock_o && interval_count_o == 12'h000
         |=> interval_count_o == $past(interval_reload_value_o);
   endproperty
   a_load: assert property (p_load)
      else $error("count did not reload");
   property p_irq;
      interval_irq_o |-> $past(interval_timer_clock_o)
         && $past(interval_count_o) == 12'h000;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt without reload");
   property p_half;
      reload_lo_wr_i && !reload_hi_wr_i |=> $stable(interval_reload_value_o);
   endproperty
   a_half: assert property (p_half)
      else $error("low byte alone changed reload");
   property p_cap;
      capture_timer_clock_o |=> !capture_timer_clock_o;
   endproperty
   a_cap: assert property (p_cap)
      else $error("capture clock pulses back to back");
   property p_sleep;
      $rose(sleep_i) |=> !processor_run_o [*2];
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("processor still runs in sleep");
   // capture pulses since reset; the periodic pulse follows every 4096th
   logic [11:0] cap_cnt;
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cap_cnt <= 12'h000;
      end else if (capture_timer_clock_o) begin
         cap_cnt <= cap_cnt + 12'h001;
      end
   end
   property p_per;
      periodic_1024_tick_o == ($past(capture_timer_clock_o)
         && $past(cap_cnt) == 12'hFFF);
   endproperty
   a_per: assert property (p_per)
      else $error("periodic tick not on 4096th capture pulse");
endmodule : csd_clock_unit_properties
bind csd_clock_unit csd_clock_unit_properties csd_clock_unit_properties_i (.*);
`default_nettype wire

// >>> dv/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, reset_n_i = 1'b0, io_wr_i = 1'b0, io_rd_i = 1'b0;
   logic extended_bank_flag_i = 1'b0, sleep_i = 1'b0;
   logic reload_lo_wr_i = 1'b0, reload_hi_wr_i = 1'b0;
   logic [7:0] io_addr_i = 8'h00, io_wr_data_i = 8'h00, reload_data_i = 8'h00;
   logic [7:0] io_rd_data_o;
   logic [11:0] interval_reload_value_o, interval_count_o;
   logic osc24_tick_i, external_clock_input_i, lp32_clock_i;
   logic processor_clock_o, processor_run_o, capture_timer_clock_o;
   logic interval_timer_clock_o, periodic_1024_tick_o, interval_irq_o;
   logic clock_output_pin_o, osc_lock_enable_o, osc_coarse_tune_enable_o;
   logic detector_always_on_o, detector_duty_cycled_o;
   int failures = 0, compares = 0;
   int cap_seen = 0;
   wire [4:0] pl = {clock_output_pin_o, interval_irq_o, interval_timer_clock_o,
      capture_timer_clock_o, processor_clock_o};
   csd_clock_unit csd_clock_unit_i (.*);
   csd_sources csd_sources_i (.clk_i(clk_sys_i), .run_i(!sleep_i),
      .osc_tick_o(osc24_tick_i), .ext_clk_o(external_clock_input_i),
      .lp_clk_o(lp32_clock_i));
   initial begin
      forever #4 clk_sys_i = !clk_sys_i;
   end
   // capture pulses since reset, for the periodic timer check
   always @(negedge clk_sys_i) begin
      if (capture_timer_clock_o === 1'b1) begin
         cap_seen++;
      end
   end
   task automatic test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %0t got %0h want %0h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      io_addr_i = a[7:0];
      extended_bank_flag_i = a[8];
      io_wr_data_i = d;
      io_wr_i = 1'b1;
      @(negedge clk_sys_i);
      io_wr_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [8:0] a, input logic [7:0] e);
      @(negedge clk_sys_i);
      io_addr_i = a[7:0];
      extended_bank_flag_i = a[8];
      io_rd_i = 1'b1;
      @(negedge clk_sys_i);
      io_rd_i = 1'b0;
      chk(io_rd_data_o, e);
   endtask : rd
   task automatic rl(input logic lo, input logic [7:0] d);
      @(negedge clk_sys_i);
      reload_lo_wr_i = lo;
      reload_hi_wr_i = !lo;
      reload_data_i = d;
      @(negedge clk_sys_i);
      reload_lo_wr_i = 1'b0;
      reload_hi_wr_i = 1'b0;
   endtask : rl
   // period between two pulses, skipping the first one after a change
   task automatic per(input int s, input int e);
      int n;
      n = 0;
      repeat (2) @(negedge clk_sys_i iff pl[s]);
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (!pl[s] && n < 5000);
      chk(n, e);
   endtask : per
   task automatic t_regs;
      rd(9'h031, 8'h8F);
      rd(9'h1E0, 8'h00);
      wr(9'h0E0, 8'h3F);
      rd(9'h1E0, 8'h00);
      wr(9'h1E0, 8'hFF);
      rd(9'h1E0, 8'h3F);
      rd(9'h131, 8'h00);
      wr(9'h1E0, 8'h00);
      chk({osc_lock_enable_o, osc_coarse_tune_enable_o}, 2'b11);
      wr(9'h039, 8'h02);
      chk({osc_lock_enable_o, osc_coarse_tune_enable_o}, 2'b10);
      wr(9'h039, 8'h01);
      chk(osc_lock_enable_o, 1'b0);
      wr(9'h039, 8'h00);
      wr(9'h030, 8'h20);
      chk(osc_lock_enable_o, 1'b0);
      wr(9'h030, 8'h00);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_cpu;
      int dv[7] = '{8, 4, 2, 1, 16, 32, 128};
      for (int c = 0; c < 7; c++) begin
         wr(9'h1E0, 8'(c));
         per(0, 5 * dv[c]);
      end
      wr(9'h1E0, 8'h07);
      per(0, 40);
      wr(9'h030, 8'h01);
      for (int c = 0; c < 7; c++) begin
         wr(9'h1E0, 8'(c));
         per(0, 10 * dv[c]);
      end
      wr(9'h030, 8'h00);
      wr(9'h1E0, 8'h00); // usb wants divide 8 or less
      $display("t_cpu done");
   endtask : t_cpu
   task automatic t_sel;
      logic [7:0] d[14] = '{8'h0F, 8'h4F, 8'h8F, 8'hCF, 8'h1F, 8'h2F, 8'h00,
         8'h04, 8'h08, 8'h0C, 8'h01, 8'h02, 8'h03, 8'h8F};
      int s[14] = '{1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2};
      int e[14] = '{10, 20, 30, 40, 20, 80, 5, 10, 15, 20, 10, 40, 10, 120};
      int o[4] = '{5, 10, 40, 40};
      int n;
      for (int i = 0; i < 14; i++) begin
         wr(9'h031, d[i]);
         per(s[i], e[i]);
      end
      for (int i = 0; i < 4; i++) begin
         wr(9'h032, 8'(i));
         per(4, o[i]);
      end
      wr(9'h031, 8'h30);
      n = 0;
      repeat (100) @(negedge clk_sys_i) n += capture_timer_clock_o;
      chk(n, 0);
      $display("t_sel done");
   endtask : t_sel
   task automatic t_pit;
      wr(9'h031, 8'h00);
      rl(1'b1, 8'h05);
      chk(interval_reload_value_o, 12'hFFF);
      rl(1'b0, 8'hF0);
      chk(interval_reload_value_o, 12'h005);
      per(3, 30);
      $display("t_pit done");
   endtask : t_pit
   task automatic t_sleep;
      int n;
      wr(9'h1E0, 8'h20);
      wr(9'h030, 8'h01);
      sleep_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      chk({processor_run_o, detector_always_on_o, detector_duty_cycled_o},
         3'b010);
      rd(9'h030, 8'h00);
      wr(9'h1E0, 8'h00);
      chk(detector_duty_cycled_o, 1'b1);
      sleep_i = 1'b0;
      n = 0;
      while (!processor_run_o && n < 500) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk(n > 78 && n < 126, 1'b1);
      $display("t_sleep done");
   endtask : t_sleep
   task automatic t_per;
      int n;
      n = 0;
      while (periodic_1024_tick_o !== 1'b1 && n < 40000) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk(cap_seen, 4096);
      $display("t_per done");
   endtask : t_per
   initial begin
      #600000;
      failures++;
      test_done;
   end
   initial begin
      repeat (10) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      t_regs;
      t_cpu;
      t_sel;
      t_pit;
      t_sleep;
      t_per;
      test_done;
   end
endmodule : testbench
`default_nettype wire
